// >>> src/bpeh_pkg.sv
`default_nettype none
package bpeh_pkg;

	// Register byte offsets
	localparam logic [11:0] BPEH_CTRL_OFF      = 12'h000;
	localparam logic [11:0] BPEH_STATUS_OFF    = 12'h004;
	localparam logic [11:0] BPEH_CFG_DATA_OFF  = 12'h008;

	// Control field positions
	localparam int BPEH_CTRL_CMD_PER_BIT  = 0;
	localparam int BPEH_CTRL_SERR_EN_BIT  = 1;
	localparam int BPEH_CTRL_BC_PER_BIT   = 2;

	// Status field positions
	localparam int BPEH_ST_PRI_DPE_BIT    = 0;
	localparam int BPEH_ST_PRI_SSE_BIT    = 1;
	localparam int BPEH_ST_PRI_MDPD_BIT   = 2;
	localparam int BPEH_ST_SEC_DPE_BIT    = 3;
	localparam int BPEH_ST_SEC_MDPD_BIT   = 4;
	localparam int BPEH_ST_W              = 5;

	// Values after reset
	localparam logic [2:0]          BPEH_CTRL_RST     = 3'h0;
	localparam logic [BPEH_ST_W-1:0] BPEH_STATUS_RST  = 5'h00;
	localparam logic [31:0]         BPEH_CFG_DATA_RST = 32'h0000_0000;

	// Cycles from data transfer to the parity error strobe
	localparam int BPEH_PERR_DLY = 2;

endpackage
`default_nettype wire

// >>> src/bpeh_top.sv
// How it works
// - Check address parity on every transaction, both buses, all commands.
// - Generate parity; pass forwarded parity unchanged with address and data.
// - Primary address parity error with command parity response: do not claim.
// - Any primary address parity error sets primary detected parity error.
// - Primary address parity error signals system error when both enables set.
// - Secondary address parity error with bridge parity response: no claim.
// - Any secondary address parity error sets secondary detected parity error.
// - Secondary address parity error signals system error when both enables set.
// - Config write parity error: accept, store, report parity error if enabled.
// - Config write parity error always sets primary detected parity error.
// - Downstream read parity error: secondary parity error two cycles later if enabled.
// - Downstream read error sets secondary detected; data-parity bit if enabled.
// - Downstream read returns data with bad parity, completes normally.
// - Unread prefetched bad-parity data is discarded, never presented.
// - Upstream read parity error: primary parity error two cycles later if enabled.
// - Upstream read error sets primary detected; data-parity bit if enabled.
// - Upstream read returns data with bad parity, completes normally.
// - Read data and parity go back exactly as received from target.
// - Initiator parity error during read return causes no further action.
`default_nettype none

module bpeh_lane (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// Forward input from the far bus or from own logic
	input  wire logic        fwd_valid,
	input  wire logic [31:0] fwd_ad,
	input  wire logic [3:0]  fwd_cbe,
	input  wire logic        fwd_par,
	input  wire logic        own_valid,
	input  wire logic [31:0] own_ad,
	input  wire logic [3:0]  own_cbe,
	// Forward output
	output logic             out_valid,
	output logic [31:0]      out_ad,
	output logic [3:0]       out_cbe,
	output logic             out_par,
	// Read return holding
	input  wire logic        hold_load,
	input  wire logic [31:0] hold_ad,
	input  wire logic        hold_par,
	input  wire logic        hold_take,
	input  wire logic        hold_discard,
	output logic             rd_valid,
	output logic [31:0]      rd_ad,
	output logic             rd_par
);
	logic        hv_q;
	logic [31:0] had_q;
	logic        hpar_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_ad    <= 32'h0000_0000;
			out_cbe   <= 4'h0;
			out_par   <= 1'b0;
		end else if (ce) begin
			out_valid <= fwd_valid | own_valid;
			if (own_valid) begin
				out_ad  <= own_ad;
				out_cbe <= own_cbe;
				out_par <= ^{own_ad, own_cbe};
			end else if (fwd_valid) begin
				out_ad  <= fwd_ad;
				out_cbe <= fwd_cbe;
				out_par <= fwd_par;
			end
		end
	end

	// One word held; a later load replaces unread data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hv_q   <= 1'b0;
			had_q  <= 32'h0000_0000;
			hpar_q <= 1'b0;
		end else if (ce) begin
			if (hold_load) begin
				hv_q   <= 1'b1;
				had_q  <= hold_ad;
				hpar_q <= hold_par;
			end else if (hold_discard || (hold_take && hv_q)) begin
				hv_q <= 1'b0;
			end
		end
	end

	// Presented only on a take; a take with a discard in the same cycle loads rd_ad and rd_par but keeps rd_valid low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_valid <= 1'b0;
			rd_ad    <= 32'h0000_0000;
			rd_par   <= 1'b0;
		end else if (ce) begin
			rd_valid <= hold_take & hv_q & ~hold_discard;
			if (hold_take && hv_q) begin
				rd_ad  <= had_q;
				rd_par <= hpar_q;
			end
		end
	end
endmodule

module bpeh_top
	import bpeh_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Primary address phase and claim
	input  wire logic        pri_addr_valid,
	input  wire logic [31:0] pri_ad,
	input  wire logic [3:0]  pri_cbe,
	input  wire logic        pri_par,
	input  wire logic        pri_claim_req,
	output logic             primary_devsel,
	// Secondary address phase and claims
	input  wire logic        sec_addr_valid,
	input  wire logic [31:0] sec_ad,
	input  wire logic [3:0]  sec_cbe,
	input  wire logic        sec_par,
	input  wire logic        sec1_claim_req,
	input  wire logic        sec2_claim_req,
	output logic             sec1_devsel,
	output logic             sec2_devsel,
	// Own config write, primary side
	input  wire logic        cfg_wr_valid,
	input  wire logic [31:0] cfg_wr_data,
	input  wire logic [3:0]  cfg_wr_be,
	input  wire logic        cfg_wr_par,
	output logic             primary_trdy,
	// Own generated data toward each bus
	input  wire logic        pri_own_valid,
	input  wire logic [31:0] pri_own_ad,
	input  wire logic [3:0]  pri_own_cbe,
	input  wire logic        sec_own_valid,
	input  wire logic [31:0] sec_own_ad,
	input  wire logic [3:0]  sec_own_cbe,
	// Forwarded address and data
	output logic             sec_fwd_valid,
	output logic [31:0]      sec_fwd_ad,
	output logic [3:0]       sec_fwd_cbe,
	output logic             sec_fwd_par,
	output logic             pri_fwd_valid,
	output logic [31:0]      pri_fwd_ad,
	output logic [3:0]       pri_fwd_cbe,
	output logic             pri_fwd_par,
	// Downstream read: data from secondary target, returned to primary
	input  wire logic        sec_rd_valid,
	input  wire logic [31:0] sec_rd_ad,
	input  wire logic [3:0]  sec_rd_be,
	input  wire logic        sec_rd_par,
	input  wire logic        pri_rd_take,
	input  wire logic        pri_rd_discard,
	output logic             pri_rd_valid,
	output logic [31:0]      pri_rd_ad,
	output logic             pri_rd_par,
	// Upstream read: data from primary target, returned to secondary
	input  wire logic        pri_rd_in_valid,
	input  wire logic [31:0] pri_rd_in_ad,
	input  wire logic [3:0]  pri_rd_in_be,
	input  wire logic        pri_rd_in_par,
	input  wire logic        sec_rd_take,
	input  wire logic        sec_rd_discard,
	output logic             sec_rd_out_valid,
	output logic [31:0]      sec_rd_out_ad,
	output logic             sec_rd_out_par,
	// Error signalling
	output logic             primary_serr,
	output logic             primary_perr,
	output logic             secondary_perr
);
	logic                  cmd_per_q;
	logic                  serr_en_q;
	logic                  bc_per_q;
	logic [BPEH_ST_W-1:0]  status_q;
	logic [BPEH_ST_W-1:0]  status_set;
	logic [BPEH_ST_W-1:0]  status_clr;
	logic [31:0]           cfg_data_q;
	logic                  pri_ape_q;
	logic                  sec_ape_q;
	logic                  pri_ape;
	logic                  sec_ape;
	logic                  cfg_dpe;
	logic                  dn_rd_dpe;
	logic                  up_rd_dpe;
	logic [BPEH_PERR_DLY-1:0] pperr_sh_q;
	logic [BPEH_PERR_DLY-1:0] sperr_sh_q;
	logic                  apb_setup;
	logic                  apb_wr;

	// PCI even parity: AD, C/BE and PAR together must XOR to zero
	assign pri_ape   = pri_addr_valid & (^{pri_ad, pri_cbe, pri_par});
	assign sec_ape   = sec_addr_valid & (^{sec_ad, sec_cbe, sec_par});
	assign cfg_dpe   = cfg_wr_valid & (^{cfg_wr_data, cfg_wr_be, cfg_wr_par});
	assign dn_rd_dpe = sec_rd_valid & (^{sec_rd_ad, sec_rd_be, sec_rd_par});
	assign up_rd_dpe = pri_rd_in_valid & (^{pri_rd_in_ad, pri_rd_in_be, pri_rd_in_par});

	// Address parity result held until the next address phase on that bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_ape_q <= 1'b0;
			sec_ape_q <= 1'b0;
		end else if (ce) begin
			if (pri_addr_valid)
				pri_ape_q <= pri_ape;
			if (sec_addr_valid)
				sec_ape_q <= sec_ape;
		end
	end

	// Claims; without parity response a bad address is claimed as usual
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_devsel <= 1'b0;
			sec1_devsel    <= 1'b0;
			sec2_devsel    <= 1'b0;
		end else if (ce) begin
			primary_devsel <= pri_claim_req & ~(pri_ape_q & cmd_per_q);
			sec1_devsel    <= sec1_claim_req & ~(sec_ape_q & bc_per_q);
			sec2_devsel    <= sec2_claim_req & ~(sec_ape_q & bc_per_q);
		end
	end

	// System error: one cycle pulse per cycle with an enabled address parity error on either bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			primary_serr <= 1'b0;
		else if (ce)
			primary_serr <= serr_en_q & ((pri_ape & cmd_per_q) | (sec_ape & bc_per_q));
	end

	// Config write: always accepted and stored, parity or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_trdy <= 1'b0;
			cfg_data_q   <= BPEH_CFG_DATA_RST;
		end else if (ce) begin
			primary_trdy <= cfg_wr_valid;
			if (cfg_wr_valid)
				cfg_data_q <= cfg_wr_data;
		end
	end

	// Parity error strobes, a fixed delay after the data transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pperr_sh_q <= '0;
			sperr_sh_q <= '0;
		end else if (ce) begin
			pperr_sh_q <= {pperr_sh_q[BPEH_PERR_DLY-2:0],
				cmd_per_q & (cfg_dpe | up_rd_dpe)};
			sperr_sh_q <= {sperr_sh_q[BPEH_PERR_DLY-2:0], bc_per_q & dn_rd_dpe};
		end
	end
	assign primary_perr   = pperr_sh_q[BPEH_PERR_DLY-1];
	assign secondary_perr = sperr_sh_q[BPEH_PERR_DLY-1];

	// Status sources
	always_comb begin
		status_set = '0;
		status_set[BPEH_ST_PRI_DPE_BIT]  = pri_ape | cfg_dpe | up_rd_dpe;
		status_set[BPEH_ST_PRI_SSE_BIT]  = serr_en_q & ((pri_ape & cmd_per_q) | (sec_ape & bc_per_q));
		status_set[BPEH_ST_PRI_MDPD_BIT] = up_rd_dpe & cmd_per_q;
		status_set[BPEH_ST_SEC_DPE_BIT]  = sec_ape | dn_rd_dpe;
		status_set[BPEH_ST_SEC_MDPD_BIT] = dn_rd_dpe & bc_per_q;
	end

	// APB: no wait state, pready answers in the first access cycle
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready & pwrite;

	always_comb begin
		status_clr = '0;
		if (apb_wr && paddr == BPEH_STATUS_OFF)
			status_clr = pwdata[BPEH_ST_W-1:0];
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_q <= BPEH_STATUS_RST;
		else if (ce)
			status_q <= (status_q & ~status_clr) | status_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_per_q <= BPEH_CTRL_RST[BPEH_CTRL_CMD_PER_BIT];
			serr_en_q <= BPEH_CTRL_RST[BPEH_CTRL_SERR_EN_BIT];
			bc_per_q  <= BPEH_CTRL_RST[BPEH_CTRL_BC_PER_BIT];
		end else if (ce && apb_wr && paddr == BPEH_CTRL_OFF) begin
			cmd_per_q <= pwdata[BPEH_CTRL_CMD_PER_BIT];
			serr_en_q <= pwdata[BPEH_CTRL_SERR_EN_BIT];
			bc_per_q  <= pwdata[BPEH_CTRL_BC_PER_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= apb_setup;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (apb_setup) begin
				case (paddr)
					BPEH_CTRL_OFF: begin
						prdata[BPEH_CTRL_CMD_PER_BIT] <= cmd_per_q;
						prdata[BPEH_CTRL_SERR_EN_BIT] <= serr_en_q;
						prdata[BPEH_CTRL_BC_PER_BIT]  <= bc_per_q;
					end
					BPEH_STATUS_OFF: begin
						prdata[BPEH_ST_W-1:0] <= status_q;
					end
					BPEH_CFG_DATA_OFF: begin
						prdata <= cfg_data_q;
					end
					default: begin
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Downstream: primary to secondary forwarding, read data back to primary.
	// An initiator's own parity report on returned data is not watched at all.
	bpeh_lane u_down (
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.fwd_valid    (pri_addr_valid),
		.fwd_ad       (pri_ad),
		.fwd_cbe      (pri_cbe),
		.fwd_par      (pri_par),
		.own_valid    (sec_own_valid),
		.own_ad       (sec_own_ad),
		.own_cbe      (sec_own_cbe),
		.out_valid    (sec_fwd_valid),
		.out_ad       (sec_fwd_ad),
		.out_cbe      (sec_fwd_cbe),
		.out_par      (sec_fwd_par),
		.hold_load    (sec_rd_valid),
		.hold_ad      (sec_rd_ad),
		.hold_par     (sec_rd_par),
		.hold_take    (pri_rd_take),
		.hold_discard (pri_rd_discard),
		.rd_valid     (pri_rd_valid),
		.rd_ad        (pri_rd_ad),
		.rd_par       (pri_rd_par)
	);

	// Upstream: secondary to primary forwarding, read data back to secondary
	bpeh_lane u_up (
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.fwd_valid    (sec_addr_valid),
		.fwd_ad       (sec_ad),
		.fwd_cbe      (sec_cbe),
		.fwd_par      (sec_par),
		.own_valid    (pri_own_valid),
		.own_ad       (pri_own_ad),
		.own_cbe      (pri_own_cbe),
		.out_valid    (pri_fwd_valid),
		.out_ad       (pri_fwd_ad),
		.out_cbe      (pri_fwd_cbe),
		.out_par      (pri_fwd_par),
		.hold_load    (pri_rd_in_valid),
		.hold_ad      (pri_rd_in_ad),
		.hold_par     (pri_rd_in_par),
		.hold_take    (sec_rd_take),
		.hold_discard (sec_rd_discard),
		.rd_valid     (sec_rd_out_valid),
		.rd_ad        (sec_rd_out_ad),
		.rd_par       (sec_rd_out_par)
	);
endmodule
`default_nettype wire

// >>> src/unused_marker_none.sv
`default_nettype none
`default_nettype wire

// >>> testbench/bpeh_top_assertions.sv
`default_nettype none
module bpeh_top_chk
	import bpeh_pkg::*;
(
	// Clock, reset and register bus
	input wire logic        pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, pri_ad, sec_ad, sec_fwd_ad, sec_rd_ad, pri_rd_in_ad, cfg_wr_data,
	// Bus phases and answers
	input wire logic [3:0]  pri_cbe, sec_cbe, cfg_wr_be, sec_rd_be, pri_rd_in_be,
	input wire logic        pri_addr_valid, pri_par, pri_claim_req, primary_devsel, sec_addr_valid, sec_par,
	input wire logic        sec1_claim_req, sec1_devsel, cfg_wr_valid, cfg_wr_par, primary_trdy, sec_own_valid,
	input wire logic        sec_fwd_valid, sec_fwd_par, sec_rd_valid, sec_rd_par, pri_rd_in_valid, pri_rd_in_par,
	input wire logic        primary_serr, primary_perr, secondary_perr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] ctrl_q;
	logic       cper, sen, bper, pbad, sbad, cbad, dbad, ubad;
	// Control is not visible at the ports, so shadow completed writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= 3'h0;
		else if (psel && penable && pready && pwrite && paddr == BPEH_CTRL_OFF)
			ctrl_q <= pwdata[2:0];
	end
	assign cper = ctrl_q[BPEH_CTRL_CMD_PER_BIT];
	assign sen  = ctrl_q[BPEH_CTRL_SERR_EN_BIT];
	assign bper = ctrl_q[BPEH_CTRL_BC_PER_BIT];
	assign pbad = ^{pri_ad, pri_cbe, pri_par};
	assign sbad = ^{sec_ad, sec_cbe, sec_par};
	assign cbad = ^{cfg_wr_data, cfg_wr_be, cfg_wr_par};
	assign dbad = ^{sec_rd_ad, sec_rd_be, sec_rd_par};
	assign ubad = ^{pri_rd_in_ad, pri_rd_in_be, pri_rd_in_par};

	property p_pri_gate;
		pri_addr_valid && pbad && cper ##1 pri_claim_req && !pri_addr_valid |=> !primary_devsel;
	endproperty
	a_pri_gate: assert property (p_pri_gate) else $error("primary claim after bad address");
	property p_pri_claim;
		pri_addr_valid && (!pbad || !cper) ##1 pri_claim_req && !pri_addr_valid |=> primary_devsel;
	endproperty
	a_pri_claim: assert property (p_pri_claim) else $error("primary claim missing");
	property p_sec_gate;
		sec_addr_valid && sbad && bper ##1 sec1_claim_req && !sec_addr_valid |=> !sec1_devsel;
	endproperty
	a_sec_gate: assert property (p_sec_gate) else $error("secondary claim after bad address");
	property p_pri_serr;
		pri_addr_valid && pbad && !sec_addr_valid |=> primary_serr == (cper && sen);
	endproperty
	a_pri_serr: assert property (p_pri_serr) else $error("system error on primary address wrong");
	property p_sec_serr;
		sec_addr_valid && sbad && !pri_addr_valid |=> primary_serr == (bper && sen);
	endproperty
	a_sec_serr: assert property (p_sec_serr) else $error("system error on secondary address wrong");
	property p_cfg;
		cfg_wr_valid |=> primary_trdy ##1 primary_perr == $past(cbad && cper, 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config write answer wrong");
	property p_dn_perr;
		sec_rd_valid |-> ##2 secondary_perr == $past(dbad && bper, 2);
	endproperty
	a_dn_perr: assert property (p_dn_perr) else $error("downstream read error strobe wrong");
	property p_up_perr;
		pri_rd_in_valid && !cfg_wr_valid |-> ##2 primary_perr == $past(ubad && cper, 2);
	endproperty
	a_up_perr: assert property (p_up_perr) else $error("upstream read error strobe wrong");
	property p_fwd;
		pri_addr_valid && !sec_own_valid |=> sec_fwd_valid && sec_fwd_par == $past(pri_par) && sec_fwd_ad == $past(pri_ad);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forwarded address or parity altered");
	c_gate: cover property (pri_addr_valid && pbad && cper);
	c_dn: cover property (sec_rd_valid && dbad && bper ##2 secondary_perr);
	c_cfg: cover property (cfg_wr_valid && cbad ##2 primary_perr);
endmodule
bind bpeh_top bpeh_top_chk u_chk (.*);
`default_nettype wire

// >>> testbench/bpeh_pci_target.sv
`default_nettype none
module bpeh_pci_target (
	// Clock
	input  wire logic   pclk,
	// Read data from the secondary and primary targets
	output logic        sec_rd_valid, pri_rd_in_valid, sec_rd_par, pri_rd_in_par,
	output logic [31:0] sec_rd_ad, pri_rd_in_ad,
	output logic [3:0]  sec_rd_be, pri_rd_in_be
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{sec_rd_valid, pri_rd_in_valid, sec_rd_par, pri_rd_in_par} = 4'h0;
		{sec_rd_ad, pri_rd_in_ad, sec_rd_be, pri_rd_in_be} = 72'h0;
	end
	// One data phase from both targets; bad breaks the even parity
	task automatic ret(input logic [31:0] ad, input logic bad);
		@(posedge pclk);
		{sec_rd_valid, pri_rd_in_valid} <= 2'h3;
		{sec_rd_ad, sec_rd_be, sec_rd_par} <= {ad, 4'h3, ^{ad, 4'h3} ^ bad};
		{pri_rd_in_ad, pri_rd_in_be, pri_rd_in_par} <= {~ad, 4'hC, ^{~ad, 4'hC} ^ bad};
		@(posedge pclk);
		// Released lines must not keep showing the old word
		{sec_rd_valid, pri_rd_in_valid} <= 2'h0;
		{sec_rd_ad, sec_rd_par, pri_rd_in_ad, pri_rd_in_par} <= ~{sec_rd_ad, sec_rd_par, pri_rd_in_ad, pri_rd_in_par};
	endtask
endmodule
`default_nettype wire

// >>> testbench/bpeh_top_test.sv
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module bpeh_top_test;
	import bpeh_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        pri_addr_valid = 1'h0, pri_par = 1'h0, pri_claim_req = 1'h0, sec_addr_valid = 1'h0;
	logic        sec_par = 1'h0, sec1_claim_req = 1'h0, sec2_claim_req = 1'h0, cfg_wr_valid = 1'h0;
	logic        cfg_wr_par = 1'h0, pri_own_valid = 1'h0, sec_own_valid = 1'h0, pri_rd_take = 1'h0;
	logic        pri_rd_discard = 1'h0, sec_rd_take = 1'h0, sec_rd_discard = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, cfg_wr_data = 32'h0, pri_own_ad = 32'h0, sec_own_ad = 32'h0;
	logic [31:0] pri_ad = 32'h8000_0010, sec_ad = 32'h0000_0C00;
	logic [3:0]  pri_cbe = 4'h0, sec_cbe = 4'h0, cfg_wr_be = 4'h0, pri_own_cbe = 4'h0, sec_own_cbe = 4'h0;
	logic        pready, pslverr, primary_devsel, sec1_devsel, sec2_devsel, primary_trdy, sec_fwd_valid;
	logic        sec_fwd_par, pri_fwd_valid, pri_fwd_par, pri_rd_valid, pri_rd_par, sec_rd_out_valid;
	logic        sec_rd_out_par, primary_serr, primary_perr, secondary_perr, err;
	logic        sec_rd_valid, sec_rd_par, pri_rd_in_valid, pri_rd_in_par;
	logic [31:0] prdata, sec_fwd_ad, pri_fwd_ad, pri_rd_ad, sec_rd_out_ad, sec_rd_ad, pri_rd_in_ad, rd;
	logic [3:0]  sec_fwd_cbe, pri_fwd_cbe, sec_rd_be, pri_rd_in_be;
	int          failures = 0, total_checks = 0, cyc = 0;

	bpeh_top dut (.*);
	bpeh_pci_target tgt (.*);

	always #20 pclk = ~pclk;
	// Whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	function automatic logic [31:0] st(input logic pd, ps, pm, sd, sm);
		logic [31:0] v = 32'h0;
		{v[BPEH_ST_PRI_DPE_BIT], v[BPEH_ST_PRI_SSE_BIT], v[BPEH_ST_PRI_MDPD_BIT]} = {pd, ps, pm};
		{v[BPEH_ST_SEC_DPE_BIT], v[BPEH_ST_SEC_MDPD_BIT]} = {sd, sm};
		return v;
	endfunction

	task automatic t_regs();
		apb(0, BPEH_CTRL_OFF, 0);
		`CHK("ctrl reset", 32'(BPEH_CTRL_RST), rd)
		apb(0, BPEH_STATUS_OFF, 0);
		`CHK("status reset", 32'(BPEH_STATUS_RST), rd)
		apb(0, BPEH_CFG_DATA_OFF, 0);
		`CHK("cfg reset", BPEH_CFG_DATA_RST, rd)
		apb(1, BPEH_CTRL_OFF, 32'h7);
		apb(0, BPEH_CTRL_OFF, 0);
		`CHK("ctrl rw", 32'h7, rd)
		apb(0, 12'h0FC, 0);
		`CHK("unmapped err", 1'h1, err)
		`CHK("unmapped data", 32'h0, rd)
	endtask

	task automatic t_addr();
		for (int k = 0; k < 8; k++) begin
			apb(1, BPEH_CTRL_OFF, k);
			@(posedge pclk);
			{pri_addr_valid, pri_cbe, pri_par} <= {1'h1, 4'(k), ~^{pri_ad, 4'(k)}};
			@(posedge pclk);
			{pri_addr_valid, pri_claim_req} <= 2'h1;
			{sec_addr_valid, sec_cbe, sec_par} <= {1'h1, ~4'(k), ~^{sec_ad, ~4'(k)}};
			#1;
			`CHK("serr pri", k[0] & k[1], primary_serr)
			`CHK("sec fwd par", pri_par, sec_fwd_par)
			`CHK("sec fwd ad", {1'h1, pri_ad, 4'(k)}, {sec_fwd_valid, sec_fwd_ad, sec_fwd_cbe})
			@(posedge pclk);
			{pri_claim_req, sec_addr_valid, sec1_claim_req, sec2_claim_req} <= 4'h3;
			#1;
			`CHK("pri devsel", ~k[0], primary_devsel)
			`CHK("serr sec", k[1] & k[2], primary_serr)
			`CHK("pri fwd par", sec_par, pri_fwd_par)
			`CHK("pri fwd ad", {1'h1, sec_ad, ~4'(k)}, {pri_fwd_valid, pri_fwd_ad, pri_fwd_cbe})
			@(posedge pclk);
			{sec1_claim_req, sec2_claim_req} <= 2'h0;
			#1;
			`CHK("sec1 devsel", ~k[2], sec1_devsel)
			`CHK("sec2 devsel", ~k[2], sec2_devsel)
			apb(0, BPEH_STATUS_OFF, 0);
			`CHK("addr status", st(1, k[1] & (k[0] | k[2]), 0, 1, 0), rd)
			apb(1, BPEH_STATUS_OFF, 32'h1F);
		end
		@(posedge pclk);
		{sec_own_valid, sec_own_ad, pri_own_valid, pri_own_ad} <= {1'h1, 32'h7, 1'h1, 32'h3};
		@(posedge pclk);
		{sec_own_valid, pri_own_valid} <= 2'h0;
		#1;
		`CHK("own sec par", 1'h1, sec_fwd_par)
		`CHK("own pri par", 1'h0, pri_fwd_par)
	endtask

	task automatic t_cfg();
		for (int p = 0; p < 2; p++) begin
			logic [31:0] d;
			d = 32'h5A00_0000 | 32'(p);
			apb(1, BPEH_CTRL_OFF, 32'(p));
			@(posedge pclk);
			{cfg_wr_valid, cfg_wr_data, cfg_wr_be, cfg_wr_par} <= {1'h1, d, 4'hF, ~^{d, 4'hF}};
			@(posedge pclk);
			cfg_wr_valid <= 1'h0;
			#1;
			`CHK("cfg trdy", 1'h1, primary_trdy)
			@(posedge pclk);
			#1;
			`CHK("cfg perr", p[0], primary_perr)
			apb(0, BPEH_CFG_DATA_OFF, 0);
			`CHK("cfg data", d, rd)
			apb(0, BPEH_STATUS_OFF, 0);
			`CHK("cfg status", st(1, 0, 0, 0, 0), rd)
			apb(1, BPEH_STATUS_OFF, 32'h1F);
		end
	endtask

	task automatic t_reads();
		for (int p = 0; p < 2; p++) begin
			logic [31:0] a;
			a = 32'hC3C3_0F0E + 32'(p);
			apb(1, BPEH_CTRL_OFF, p ? 32'h5 : 32'h0);
			tgt.ret(a, 1'h1);
			@(posedge pclk);
			#1;
			`CHK("dn perr", p[0], secondary_perr)
			`CHK("up perr", p[0], primary_perr)
			@(posedge pclk);
			{pri_rd_take, sec_rd_take} <= 2'h3;
			@(posedge pclk);
			{pri_rd_take, sec_rd_take} <= 2'h0;
			#1;
			`CHK("dn ret", {1'h1, a, ~^{a, 4'h3}}, {pri_rd_valid, pri_rd_ad, pri_rd_par})
			// Initiator side: its own check of the returned word must see the bad parity
			`CHK("initiator parity", 1'h1, ^{pri_rd_ad, 4'h3, pri_rd_par})
			`CHK("up ret", {1'h1, ~a, ~^{~a, 4'hC}}, {sec_rd_out_valid, sec_rd_out_ad, sec_rd_out_par})
			tgt.ret(~a, 1'h1);
			{pri_rd_discard, sec_rd_discard} <= 2'h3;
			@(posedge pclk);
			{pri_rd_discard, sec_rd_discard, pri_rd_take, sec_rd_take} <= 4'h3;
			@(posedge pclk);
			{pri_rd_take, sec_rd_take} <= 2'h0;
			#1;
			`CHK("dn dropped", 1'h0, pri_rd_valid)
			`CHK("up dropped", 1'h0, sec_rd_out_valid)
			apb(0, BPEH_STATUS_OFF, 0);
			`CHK("rd status", st(1, 0, p[0], 1, p[0]), rd)
			apb(1, BPEH_STATUS_OFF, 32'h1F);
		end
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_addr();
		t_cfg();
		t_reads();
		print_verdict();
	end
endmodule
`default_nettype wire
